/* rtl/ifd_cfg.svh */
// constants for the input function dispatch block
// assumes a single 125 MHz sys_clk and synchronous active-high reset
// Function
// - forced-terminal input active: frequency and run sources come from terminals
// - forced-terminal input inactive: stored frequency and run source settings used
// - forced-terminal change while running: stop motor first, then switch sources
// - torque-permit input active enables torque command; inactive keeps normal mode
// - power-total-clear input active clears accumulated input power total
// - seven program inputs each appear as general bits to user program
// - analog-hold active freezes analog command; inactive passes it through
// - with hold active, up/down adjustment uses the held value as reference
// - up/down memory mode enabled with analog hold active: up/down result stored to nonvolatile memory
// - at reset release with hold still active, keep the value held before
// - set switch under hold keeps frequency; recapture only after hold re-asserts
// - three position selects form index, third most significant, choosing 0..7
// - no position select assigned: stored position zero is used
// - position index accepted only after selects stable for determination delay
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH
`define IFD_NUM_TERM 7
`define IFD_CODE_W 7
`define IFD_FN_FORCE 7'h33
`define IFD_FN_TORQUE 7'h34
`define IFD_FN_PCLR 7'h35
`define IFD_FN_PRG0 7'h38
`define IFD_FN_PRG6 7'h3E
`define IFD_FN_AHOLD 7'h41
`define IFD_FN_POS0 7'h42
`define IFD_FN_POS2 7'h44
`define IFD_FN_NONE 7'h7F
`define IFD_ANA_W 12
`define IFD_DLY_W 16
`define IFD_SRC_W 2
`define IFD_SRC_TERM 2'h1
`define IFD_SYNC_SETTLE 2'h2
`endif

/* rtl/ifd_pkg.sv */
// types for the input function dispatch block
// assumes ifd_cfg.svh is included by users of the constants
package ifd_pkg;
	typedef enum logic [1:0] {
		IFD_SW_IDLE,
		IFD_SW_STOP,
		IFD_SW_APPLY
	} ifd_sw_state_t;
endpackage

/* rtl/ifd_sync.sv */
// two-flop synchroniser for one pin
// assumes the pin is asynchronous to sys_clk
module ifd_sync (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic pin,
	output logic sync
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	always_comb begin
		meta_d = pin;
		sync_d = meta_q;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign sync = sync_q;
endmodule // ifd_sync

/* rtl/ifd_top.sv */
// maps multifunction input terminals to drive functions
// assumes terminals are raw pins; settings and analog value are on sys_clk
`include "ifd_cfg.svh"
module ifd_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [6:0] term_pins,
	input wire logic [48:0] term_codes,
	input wire logic [1:0] freq_source_setting,
	input wire logic [1:0] run_cmd_source_setting,
	input wire logic motor_running,
	input wire logic [11:0] analog_in,
	input wire logic updown_mem_en,
	input wire logic [11:0] updown_result,
	input wire logic set_select,
	input wire logic [15:0] pos_det_delay,
	output logic [1:0] freq_src_eff,
	output logic [1:0] run_src_eff,
	output logic stop_request,
	output logic torque_cmd_permit,
	output logic power_total_clear,
	output logic [6:0] program_gp_inputs,
	output logic [11:0] analog_cmd,
	output logic [11:0] updown_ref,
	output logic nv_store_stb,
	output logic [11:0] nv_store_data,
	output logic [2:0] pos_index,
	output logic pos_index_valid
);
	logic [6:0] term_s;
	genvar gi;
	generate
		for (gi = 0; gi < `IFD_NUM_TERM; gi++) begin : g_sync
			ifd_sync u_sync (
				.sys_clk(sys_clk),
				.srst(srst),
				.pin(term_pins[gi]),
				.sync(term_s[gi])
			);
		end
	endgenerate

	// function decode: OR of every terminal carrying the code
	// a code on no terminal leaves its function inactive
	logic f_force, f_torque, f_pclr, f_ahold;
	logic [6:0] f_prg;
	logic [2:0] f_pos;
	logic any_pos;
	always_comb begin
		f_force = 1'b0;
		f_torque = 1'b0;
		f_pclr = 1'b0;
		f_ahold = 1'b0;
		f_prg = 7'h00;
		f_pos = 3'h0;
		any_pos = 1'b0;
		for (int i = 0; i < `IFD_NUM_TERM; i++) begin
			logic [6:0] c;
			c = term_codes[i*7 +: 7];
			if (c == `IFD_FN_FORCE) f_force = f_force | term_s[i];
			if (c == `IFD_FN_TORQUE) f_torque = f_torque | term_s[i];
			if (c == `IFD_FN_PCLR) f_pclr = f_pclr | term_s[i];
			if (c == `IFD_FN_AHOLD) f_ahold = f_ahold | term_s[i];
			for (int k = 0; k < 7; k++) begin
				if (c == `IFD_FN_PRG0 + 7'(k)) f_prg[k] = f_prg[k] | term_s[i];
			end
			for (int k = 0; k < 3; k++) begin
				if (c == `IFD_FN_POS0 + 7'(k)) begin
					f_pos[k] = f_pos[k] | term_s[i];
					any_pos = 1'b1;
				end
			end
		end
		if (!any_pos) f_pos = 3'h0;
	end

	// source forcing with stop-before-switch
	// a change while running waits for the motor to stop
	ifd_pkg::ifd_sw_state_t sw_q, sw_d;
	logic force_q, force_d, stop_q, stop_d;
	logic [1:0] fsrc_q, fsrc_d, rsrc_q, rsrc_d;
	logic torque_q, torque_d, pclr_q, pclr_d;
	logic [6:0] prg_q, prg_d;
	always_comb begin
		sw_d = sw_q;
		force_d = force_q;
		stop_d = 1'b0;
		unique case (sw_q)
			ifd_pkg::IFD_SW_IDLE: begin
				if (f_force != force_q) begin
					if (motor_running) begin
						sw_d = ifd_pkg::IFD_SW_STOP;
						stop_d = 1'b1;
					end else begin
						force_d = f_force;
					end
				end
			end
			ifd_pkg::IFD_SW_STOP: begin
				stop_d = 1'b1;
				if (!motor_running) sw_d = ifd_pkg::IFD_SW_APPLY;
			end
			ifd_pkg::IFD_SW_APPLY: begin
				force_d = f_force;
				sw_d = ifd_pkg::IFD_SW_IDLE;
			end
		endcase
		fsrc_d = force_d ? `IFD_SRC_TERM : freq_source_setting;
		rsrc_d = force_d ? `IFD_SRC_TERM : run_cmd_source_setting;
		torque_d = f_torque;
		pclr_d = f_pclr;
		prg_d = f_prg;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sw_q <= ifd_pkg::IFD_SW_IDLE;
			force_q <= 1'b0;
			stop_q <= 1'b0;
			fsrc_q <= 2'h0;
			rsrc_q <= 2'h0;
			torque_q <= 1'b0;
			pclr_q <= 1'b0;
			prg_q <= 7'h00;
		end else begin
			sw_q <= sw_d;
			force_q <= force_d;
			stop_q <= stop_d;
			fsrc_q <= fsrc_d;
			rsrc_q <= rsrc_d;
			torque_q <= torque_d;
			pclr_q <= pclr_d;
			prg_q <= prg_d;
		end
	end

	// analog hold; held value survives reset so it is reused after release
	logic [11:0] held_q, held_d, ana_q, ana_d, uref_q, uref_d, nvd_q, nvd_d;
	logic hold_prev_q, hold_prev_d, nvs_q, nvs_d;
	// hold edge tracking waits until the synchronisers show real pin levels
	logic [1:0] sv_q, sv_d;
	always_comb begin
		held_d = held_q;
		sv_d = (sv_q == `IFD_SYNC_SETTLE) ? sv_q : sv_q + 2'h1;
		hold_prev_d = (sv_q == `IFD_SYNC_SETTLE) ? f_ahold : hold_prev_q;
		if (f_ahold && !hold_prev_q) held_d = analog_in;
		ana_d = f_ahold ? held_q : analog_in;
		uref_d = f_ahold ? held_q : analog_in;
		nvs_d = updown_mem_en && f_ahold && (updown_result != nvd_q);
		nvd_d = nvs_d ? updown_result : nvd_q;
	end
	always_ff @(posedge sys_clk) begin
		held_q <= held_d;
		if (srst) begin
			hold_prev_q <= 1'b1;
			sv_q <= 2'h0;
			ana_q <= 12'h000;
			uref_q <= 12'h000;
			nvs_q <= 1'b0;
			nvd_q <= 12'h000;
		end else begin
			hold_prev_q <= hold_prev_d;
			sv_q <= sv_d;
			ana_q <= ana_d;
			uref_q <= uref_d;
			nvs_q <= nvs_d;
			nvd_q <= nvd_d;
		end
	end

	// position select settling
	// any candidate change restarts the settle count
	logic [2:0] pos_cand_q, pos_cand_d, pos_q, pos_d;
	logic [15:0] cnt_q, cnt_d;
	logic pv_q, pv_d;
	always_comb begin
		pos_cand_d = f_pos;
		cnt_d = cnt_q;
		pos_d = pos_q;
		pv_d = 1'b0;
		if (f_pos != pos_cand_q) begin
			cnt_d = 16'h0000;
		end else if (cnt_q < pos_det_delay) begin
			cnt_d = cnt_q + 16'h0001;
		end else begin
			pos_d = pos_cand_q;
			pv_d = 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pos_cand_q <= 3'h0;
			cnt_q <= 16'h0000;
			pos_q <= 3'h0;
			pv_q <= 1'b0;
		end else begin
			pos_cand_q <= pos_cand_d;
			cnt_q <= cnt_d;
			pos_q <= pos_d;
			pv_q <= pv_d;
		end
	end

	assign freq_src_eff = fsrc_q;
	assign run_src_eff = rsrc_q;
	assign stop_request = stop_q;
	assign torque_cmd_permit = torque_q;
	assign power_total_clear = pclr_q;
	assign program_gp_inputs = prg_q;
	assign analog_cmd = ana_q;
	assign updown_ref = uref_q;
	assign nv_store_stb = nvs_q;
	assign nv_store_data = nvd_q;
	assign pos_index = pos_q;
	assign pos_index_valid = pv_q;
endmodule // ifd_top

/* verif/ifd_chk_properties.sv */
// port checker for ifd_top, bound into every instance
// assumes codes change rarely and pins hold steady for several cycles
module ifd_chk (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [6:0] term_pins,
	input wire logic [48:0] term_codes,
	input wire logic motor_running,
	input wire logic [11:0] analog_in,
	input wire logic updown_mem_en,
	input wire logic [11:0] updown_result,
	input wire logic nv_store_stb,
	input wire logic [11:0] nv_store_data,
	input wire logic [1:0] freq_src_eff,
	input wire logic [1:0] run_src_eff,
	input wire logic stop_request,
	input wire logic torque_cmd_permit,
	input wire logic power_total_clear,
	input wire logic [6:0] program_gp_inputs,
	input wire logic [11:0] analog_cmd,
	input wire logic [11:0] updown_ref,
	input wire logic [2:0] pos_index,
	input wire logic pos_index_valid
);
	logic [48:0] cd_q, cd_d;
	logic [2:0] rc_q, rc_d, pv;
	logic [6:0] gv;
	logic rdy, fo, tq, pc, hd;
	function automatic logic act(input logic [6:0] f);
		act = 1'h0;
		for (int i = 0; i < 7; i++) act |= term_pins[i] && term_codes[i*7+:7] == f;
	endfunction
	// ready once reset and any code change lie five edges back
	always_comb begin
		cd_d = term_codes;
		rc_d = (srst || term_codes != cd_q) ? 3'h0 : rc_q + 3'(rc_q != 3'h5);
		rdy = rc_q == 3'h5;
		fo = act(7'h33);
		tq = act(7'h34);
		pc = act(7'h35);
		hd = act(7'h41);
		pv = {act(7'h44), act(7'h43), act(7'h42)};
		for (int k = 0; k < 7; k++) gv[k] = act(7'h38 + 7'(k));
	end
	always_ff @(posedge sys_clk) begin
		cd_q <= cd_d;
		rc_q <= rc_d;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_tq; rdy |-> torque_cmd_permit == $past(tq, 3); endproperty
	a_tq: assert property (p_tq) else $error("torque permit wrong");
	property p_pc; rdy |-> power_total_clear == $past(pc, 3); endproperty
	a_pc: assert property (p_pc) else $error("power clear wrong");
	property p_gp; rdy |-> program_gp_inputs == $past(gv, 3); endproperty
	a_gp: assert property (p_gp) else $error("program inputs wrong");
	property p_fo; rdy && $past(fo, 3) && $past(fo, 4) && !stop_request && !motor_running
		&& !$past(motor_running, 4) |-> freq_src_eff == 2'h1 && run_src_eff == 2'h1; endproperty
	a_fo: assert property (p_fo) else $error("forced sources wrong");
	property p_st; rdy && motor_running && $past(motor_running, 3) && $past(fo, 3) != $past(fo, 4)
		|-> stop_request && $stable(freq_src_eff); endproperty
	a_st: assert property (p_st) else $error("no stop before switch");
	property p_pa; rdy && !$past(hd, 3) && !$past(hd, 4) |-> analog_cmd == $past(analog_in); endproperty
	a_pa: assert property (p_pa) else $error("analog not passed");
	property p_fr; rdy && $past(hd, 3) && $past(hd, 4) && $past(hd, 5)
		|-> $stable(analog_cmd) && updown_ref == analog_cmd; endproperty
	a_fr: assert property (p_fr) else $error("analog hold broken");
	property p_ps; rdy && $changed(pos_index) |-> pos_index_valid && pos_index == $past(pv, 3)
		&& $past(pv, 3) == $past(pv, 5); endproperty
	a_ps: assert property (p_ps) else $error("position index early or wrong");
	property p_nv; rdy && nv_store_stb |-> $changed(nv_store_data)
		&& nv_store_data == $past(updown_result) && $past(updown_mem_en); endproperty
	a_nv: assert property (p_nv) else $error("stored result wrong");
	c_nv: cover property (nv_store_stb);
	c_stop: cover property (stop_request ##1 !stop_request);
	c_pos: cover property ($rose(pos_index_valid));
	c_hold: cover property ($rose(hd));
endmodule // ifd_chk

bind ifd_top ifd_chk u_chk (.*);

/* verif/ifd_sw.sv */
// switch model driving the terminal pins
// assumes the bench gives the wanted levels on sys_clk
module ifd_sw (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic [6:0] want,
	output logic [6:0] term_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] d_q;
	always @(posedge sys_clk) d_q <= want;
	always @(posedge sys_clk) term_pins <= slow ? d_q : want;
endmodule // ifd_sw

/* verif/ifd_top_tb_top.sv */
// self-checking bench for ifd_top
// assumes checker and switch model compiled before it
module ifd_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = '0, srst = '1, motor_running = '0, updown_mem_en = '0, set_select = '0;
	logic slow = '0, hp = '1, af = '0, look = '0;
	logic [1:0] freq_source_setting = '0, run_cmd_source_setting = '0, freq_src_eff, run_src_eff;
	logic [6:0] want = '0, term_pins, program_gp_inputs;
	logic [48:0] term_codes = '0;
	logic [48:0] cfg [3] = '{{7'h42, 7'h41, 7'h3E, 7'h38, 7'h35, 7'h34, 7'h33},
		{7'h7F, 7'h7F, 7'h7F, 7'h39, 7'h44, 7'h43, 7'h42}, '1};
	logic [11:0] analog_in = '0, updown_result = '0, held, analog_cmd, updown_ref, nv_store_data;
	logic [11:0] nvx = '0;
	logic [15:0] pos_det_delay = 16'h0003, r = 16'h0006;
	logic stop_request, torque_cmd_permit, power_total_clear, nv_store_stb, pos_index_valid;
	logic [2:0] pos_index;
	logic [53:0] q[$];
	int err_total = 0, checked = 0;
	wire [53:0] obs = {torque_cmd_permit, power_total_clear, program_gp_inputs, freq_src_eff,
		run_src_eff, stop_request, pos_index, analog_cmd, updown_ref, pos_index_valid,
		nv_store_data};
	ifd_top dut (.*);
	ifd_sw u_sw (.*);
	initial forever #4 sys_clk = ~sys_clk;
	function automatic logic [15:0] lf(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic act(input logic [6:0] p, input logic [48:0] c, input logic [6:0] f);
		act = 1'h0;
		for (int i = 0; i < 7; i++) act |= p[i] && c[i*7+:7] == f;
	endfunction
	task automatic end_sim;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input logic [53:0] e, input logic [53:0] s);
		checked++;
		if (e !== s) begin
			err_total++;
			$display("BAD obs exp %h seen %h", e, s);
		end
	endtask
	// one settled terminal pattern, expected outputs noted first
	task automatic step(input logic [48:0] c, input logic [6:0] p, input logic m);
		logic [6:0] g;
		logic f, h, o;
		logic [11:0] a;
		for (int k = 0; k < 7; k++) g[k] = act(p, c, 7'h38 + 7'(k));
		f = act(p, c, 7'h33);
		h = act(p, c, 7'h41);
		o = act(want, c, 7'h41);
		r = lf(r);
		@(posedge sys_clk);
		want <= p;
		term_codes <= c;
		motor_running <= m;
		analog_in <= r[11:0];
		updown_result <= r[11:0];
		{freq_source_setting, run_cmd_source_setting} <= r[15:12];
		{slow, set_select, updown_mem_en} <= r[2:0];
		if (h && !hp) held = r[11:0];
		hp = h;
		if (!m) af = f;
		if (r[0] && (o || h)) nvx = r[11:0];
		a = h ? held : r[11:0];
		q.push_back({act(p, c, 7'h34), act(p, c, 7'h35), g, af ? 4'h5 : r[15:12], m && f != af,
			act(p, c, 7'h44), act(p, c, 7'h43), act(p, c, 7'h42), a, a, 1'h1, nvx});
		repeat (9) @(posedge sys_clk);
		look <= ~look;
	endtask
	always @(look) begin
		#1;
		cmp(q.pop_front(), obs);
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		err_total++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		srst <= '0;
		step(cfg[0], 7'h00, 1'h0);
		for (int n = 0; n < 60; n++) begin
			if (n == 10) begin
				step(cfg[0], want | 7'h20, 1'h0);
				srst <= '1;
				repeat (8) @(posedge sys_clk);
				srst <= '0;
				nvx = '0;
				step(cfg[0], want, 1'h0);
			end
			if (n == 20) begin
				step(cfg[0], want ^ 7'h01, 1'h1);
				step(cfg[0], want, 1'h0);
			end
			step(cfg[n / 20], r[6:0], 1'h0);
			if (n % 20 == 19) $display("test %0d done", n / 20);
		end
		repeat (2) @(posedge sys_clk);
		end_sim();
	end
endmodule // ifd_top_tb_top
